// >>> verilog/fmpd_forward_decode.v
// Behaviour
// R1 - offset bits 28:16 of dword 5 are a byte position counted from the gateway register base.
// R2 - offset splits into an 8-bit register, a 3-bit dword and a 2-bit byte part.
// R3 - the requester keeps the register part in 0..127, its top bit zero.
// R4 - the requester zeroes the byte part for lengths of one dword or more.
// R5 - the requester aligns the in-register offset to the segment size.
// R6 - the requester never targets the first general register or the null register.
// R7 - length codes 000..100 mean byte, word, dword, 2 and 4 dwords; 101..111 are invalid.
// R8 - the dispatch tag in bits 7:0 of dword 5 is disregarded.
// R9 - the requester supplies a dispatch tag only for fixed-function threads ending the thread; the thread model drives a tag on every message.
// R10 - with notify set, a notification bumps the recipient's notification counter.
// R11 - with acknowledge request set, one writeback returns, only its low dword written.
// R12 - a segment longer than four dwords reports error code 110.
// R13 - a message to a gateway that is not open reports error code 010.
// R14 - only bytes covered by the length at the computed position are written.
// R15 - the requester drives reserved payload bits as zero.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fmpd_defs.vh"
module fmpd_forward_decode (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  // forward message in
  input wire msg_valid,
  output wire msg_ready,
  input wire [31:0] msg_dword5,
  input wire [127:0] msg_segment,
  input wire msg_notify,
  input wire acknowledge_request,
  input wire gateway_open,
  input wire [7:0] gateway_register_base,
  // recipient register file write
  output wire rf_wr_valid,
  output wire [7:0] rf_wr_reg,
  output wire [31:0] rf_wr_byte_en,
  output wire [255:0] rf_wr_data,
  // notification and writeback
  output wire notify_pulse,
  output wire wb_valid,
  output wire [31:0] wb_dword
);
  wire [7:0] ofs_reg;
  wire [2:0] ofs_dw;
  wire [1:0] ofs_byte;
  wire [4:0] start_byte;
  wire [2:0] len_code;
  wire [4:0] byte_count;
  wire len_valid;
  wire take;
  wire [5:0] end_byte;
  wire [31:0] lane_en;
  wire [255:0] shifted;
  wire [2:0] err_code;
  wire ok;
  reg [7:0] ctrl_ff;
  reg [2:0] irq_status_ff;
  reg [2:0] irq_mask_ff;
  reg [15:0] fwd_count_ff;
  reg [19:0] last_dest_ff;
  reg [31:0] prdata_ff;
  reg rf_wr_valid_ff;
  reg [7:0] rf_wr_reg_ff;
  reg [31:0] rf_wr_byte_en_ff;
  reg [255:0] rf_wr_data_ff;
  reg notify_ff;
  reg wb_valid_ff;
  reg [31:0] wb_dword_ff;
  reg [31:0] nxt_prdata;
  reg [2:0] nxt_irq_status;
  reg addr_hit;
  wire apb_wr;
  wire apb_setup;
  wire [2:0] irq_events;

  // dispatch tag bits 7:0 and reserved bits are never looked at
  assign ofs_reg = msg_dword5[`FMPD_REG_MSB:`FMPD_REG_LSB]; // R1 R2 R8
  assign ofs_dw = msg_dword5[`FMPD_DW_MSB:`FMPD_DW_LSB]; // R2
  assign ofs_byte = msg_dword5[`FMPD_BYTE_MSB:`FMPD_BYTE_LSB]; // R2
  assign len_code = msg_dword5[`FMPD_LEN_MSB:`FMPD_LEN_LSB];
  // byte position within the 256-bit register
  assign start_byte = {ofs_dw, ofs_byte}; // R2

  fmpd_len_decode u_len (
    .len_code(len_code),
    .byte_count(byte_count),
    .len_valid(len_valid)
  ); // R7

  assign msg_ready = ctrl_ff[`FMPD_CTRL_EN];
  assign take = msg_valid & msg_ready;

  // misaligned offsets are not trapped; alignment is the sender's duty
  assign end_byte = {1'b0, start_byte} + {1'b0, byte_count}; // R5 R4

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1)
    begin : g_lane
      assign lane_en[gi] = ({1'b0, start_byte} <= gi) &&
        (gi < end_byte); // R14
    end
  endgenerate

  // byte segment is replicated in dword 0, so a plain shift lands it right
  assign shifted = {128'h0, msg_segment} << {start_byte, 3'h0}; // R14

  assign err_code = !gateway_open ? `FMPD_ERR_CLOSED : // R13
    (!len_valid ? `FMPD_ERR_SIZE : `FMPD_ERR_OK); // R12
  assign ok = (err_code == `FMPD_ERR_OK);

  // register write, notification and writeback, one-cycle pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rf_wr_valid_ff <= 1'b0;
      rf_wr_reg_ff <= 8'h00;
      rf_wr_byte_en_ff <= 32'h00000000;
      rf_wr_data_ff <= 256'h0;
      notify_ff <= 1'b0;
      wb_valid_ff <= 1'b0;
      wb_dword_ff <= 32'h00000000;
    end
    else
    begin
      rf_wr_valid_ff <= take & ok; // R14
      notify_ff <= take & ok & msg_notify; // R10
      wb_valid_ff <= take & acknowledge_request; // R11
      if (take)
      begin
        // register number wraps within the 8-bit space
        rf_wr_reg_ff <= gateway_register_base + ofs_reg; // R1
        rf_wr_byte_en_ff <= ok ? lane_en : 32'h00000000; // R14
        rf_wr_data_ff <= shifted;
        wb_dword_ff <= {12'h000,
          ctrl_ff[`FMPD_CTRL_SFID_MSB:`FMPD_CTRL_SFID_LSB],
          13'h0000, err_code}; // R11 R12 R13
      end
    end
  end

  assign rf_wr_valid = rf_wr_valid_ff;
  assign rf_wr_reg = rf_wr_reg_ff;
  assign rf_wr_byte_en = rf_wr_byte_en_ff;
  assign rf_wr_data = rf_wr_data_ff;
  assign notify_pulse = notify_ff;
  assign wb_valid = wb_valid_ff;
  assign wb_dword = wb_dword_ff;

  // apb: zero wait states, read data captured in the setup cycle
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & addr_hit;
  assign pslverr = psel & penable & ~addr_hit;

  always @*
  begin
    addr_hit = 1'b1;
    nxt_prdata = 32'h00000000;
    case (paddr)
      `FMPD_ADDR_CTRL: nxt_prdata = {24'h000000, ctrl_ff};
      `FMPD_ADDR_IRQ_STATUS: nxt_prdata = {29'h0, irq_status_ff};
      `FMPD_ADDR_IRQ_MASK: nxt_prdata = {29'h0, irq_mask_ff};
      `FMPD_ADDR_FWD_COUNT: nxt_prdata = {16'h0000, fwd_count_ff};
      `FMPD_ADDR_LAST_DEST: nxt_prdata = {12'h000, last_dest_ff};
      default: addr_hit = 1'b0;
    endcase
  end

  assign irq_events[`FMPD_IRQ_DONE] = take & ok;
  assign irq_events[`FMPD_IRQ_SIZE] = take & gateway_open & ~len_valid;
  assign irq_events[`FMPD_IRQ_CLOSED] = take & ~gateway_open;

  // a new event beats a same-cycle write-one-to-clear
  always @*
  begin
    nxt_irq_status = irq_status_ff;
    if (apb_wr && paddr == `FMPD_ADDR_IRQ_STATUS)
      nxt_irq_status = irq_status_ff & ~pwdata[2:0];
    nxt_irq_status = nxt_irq_status | irq_events;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= `FMPD_CTRL_RST;
      irq_status_ff <= `FMPD_IRQ_RST;
      irq_mask_ff <= `FMPD_IRQ_RST;
      fwd_count_ff <= `FMPD_CNT_RST;
      last_dest_ff <= `FMPD_LAST_RST;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
      if (apb_setup && !pwrite)
        prdata_ff <= nxt_prdata;
      if (apb_wr && paddr == `FMPD_ADDR_CTRL)
        ctrl_ff <= pwdata[7:0];
      if (apb_wr && paddr == `FMPD_ADDR_IRQ_MASK)
        irq_mask_ff <= pwdata[2:0];
      // counter wraps; software reads differences
      if (take && ok)
        fwd_count_ff <= fwd_count_ff + 16'h0001;
      if (take)
        last_dest_ff <= {err_code, len_code, ofs_reg, start_byte, 1'b0};
    end
  end

  assign prdata = prdata_ff;
  assign irq = |(irq_status_ff & irq_mask_ff);
endmodule
`default_nettype wire

// >>> verilog/fmpd_defs.vh
`ifndef FMPD_DEFS_VH
`define FMPD_DEFS_VH
// payload dword 5 fields
`define FMPD_OFS_MSB 28
`define FMPD_OFS_LSB 16
`define FMPD_REG_MSB 28
`define FMPD_REG_LSB 21
`define FMPD_DW_MSB 20
`define FMPD_DW_LSB 18
`define FMPD_BYTE_MSB 17
`define FMPD_BYTE_LSB 16
`define FMPD_LEN_MSB 10
`define FMPD_LEN_LSB 8
`define FMPD_TAG_MSB 7
`define FMPD_TAG_LSB 0
// length codes
`define FMPD_LEN_BYTE 3'h0
`define FMPD_LEN_WORD 3'h1
`define FMPD_LEN_DW1 3'h2
`define FMPD_LEN_DW2 3'h3
`define FMPD_LEN_DW4 3'h4
// byte counts
`define FMPD_CNT_BYTE 5'h01
`define FMPD_CNT_WORD 5'h02
`define FMPD_CNT_DW1 5'h04
`define FMPD_CNT_DW2 5'h08
`define FMPD_CNT_DW4 5'h10
// writeback error codes
`define FMPD_ERR_OK 3'h0
`define FMPD_ERR_CLOSED 3'h2
`define FMPD_ERR_SIZE 3'h6
// apb register byte offsets
`define FMPD_ADDR_CTRL 12'h000
`define FMPD_ADDR_IRQ_STATUS 12'h004
`define FMPD_ADDR_IRQ_MASK 12'h008
`define FMPD_ADDR_FWD_COUNT 12'h00C
`define FMPD_ADDR_LAST_DEST 12'h010
// reset values
`define FMPD_CTRL_RST 8'h01
`define FMPD_IRQ_RST 3'h0
`define FMPD_CNT_RST 16'h0000
`define FMPD_LAST_RST 20'h00000
// irq bit positions
`define FMPD_IRQ_DONE 0
`define FMPD_IRQ_SIZE 1
`define FMPD_IRQ_CLOSED 2
// ctrl fields
`define FMPD_CTRL_EN 0
`define FMPD_CTRL_SFID_MSB 7
`define FMPD_CTRL_SFID_LSB 4
`endif

// >>> verilog/fmpd_len_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "fmpd_defs.vh"
module fmpd_len_decode (
  // length code in
  input wire [2:0] len_code,
  // decoded size
  output reg [4:0] byte_count,
  output reg len_valid
);
  always @*
  begin
    len_valid = 1'b1;
    case (len_code)
      `FMPD_LEN_BYTE: byte_count = `FMPD_CNT_BYTE;
      `FMPD_LEN_WORD: byte_count = `FMPD_CNT_WORD;
      `FMPD_LEN_DW1: byte_count = `FMPD_CNT_DW1;
      `FMPD_LEN_DW2: byte_count = `FMPD_CNT_DW2;
      `FMPD_LEN_DW4: byte_count = `FMPD_CNT_DW4;
      default:
      begin
        byte_count = `FMPD_CNT_BYTE;
        len_valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/fmpd_fwd_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fmpd_fwd_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // message in
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire logic [31:0] msg_dword5,
  input wire logic msg_notify,
  input wire logic acknowledge_request,
  input wire logic gateway_open,
  input wire logic [7:0] gateway_register_base,
  // results
  input wire logic rf_wr_valid,
  input wire logic [7:0] rf_wr_reg,
  input wire logic [31:0] rf_wr_byte_en,
  input wire logic notify_pulse,
  input wire logic wb_valid,
  input wire logic [31:0] wb_dword
);
  wire logic acc = msg_valid && msg_ready;
  wire logic [2:0] len = msg_dword5[10:8];
  wire logic ok = acc && gateway_open && len < 3'h5;
  wire logic [7:0] dst = gateway_register_base + msg_dword5[28:21];
  wire logic [4:0] st = msg_dword5[20:16];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence take_ok;
    ok;
  endsequence
  a_write_pulse: assert property (rf_wr_valid == $past(ok))
    else $error("write pulse wrong");
  a_reg_target: assert property (take_ok |=> rf_wr_reg == $past(dst))
    else $error("target register wrong");
  a_byte_lane: assert property (take_ok ##0 len == 3'h0
    |=> rf_wr_byte_en == 32'h1 << $past(st)) else $error("byte lane wrong");
  a_quad_lane: assert property (take_ok ##0 len == 3'h4
    |=> rf_wr_byte_en == 32'hFFFF << $past(st)) else $error("quad lanes wrong");
  a_size_code: assert property (acc && gateway_open && len > 3'h4
    |=> !rf_wr_valid && wb_dword[2:0] == 3'h6) else $error("size code wrong");
  a_closed_code: assert property (acc && !gateway_open
    |=> !notify_pulse && wb_dword[2:0] == 3'h2) else $error("closed code wrong");
  a_notify_bump: assert property (take_ok
    |=> notify_pulse == $past(msg_notify)) else $error("notify wrong");
  a_ack_back: assert property (acc |=> wb_valid == $past(acknowledge_request)
    && wb_dword[31:20] == 12'h000) else $error("writeback wrong");
endmodule
bind fmpd_forward_decode fmpd_fwd_sva chk (.*);
`default_nettype wire

// >>> tb/fmpd_thread_model.sv
`timescale 1ns/100ps
`default_nettype none
module fmpd_thread_model #(
  parameter logic [7:0] BASE = 8'hF0,
  parameter logic [127:0] SEG = 128'h0
) (
  // handshake
  input wire logic pclk,
  input wire logic msg_ready,
  // message out
  output logic msg_valid,
  output logic [31:0] msg_dword5,
  output logic [127:0] msg_segment,
  output logic msg_notify,
  output logic acknowledge_request,
  output logic gateway_open,
  output logic [7:0] gateway_register_base
);
  logic [7:0] tag_ff = 8'h3C;
  assign gateway_register_base = BASE;
  initial
  begin
    msg_valid = 1'b0;
    {msg_dword5, msg_segment} = '0;
    {gateway_open, msg_notify, acknowledge_request} = 3'h0;
  end
  task send(input logic [6:0] r, input logic [4:0] sb, input logic [2:0] l,
    input logic [2:0] fl);
    logic [4:0] al;
    al = l > 3'h4 ? 5'h1F : 5'h1F << l;
    @(posedge pclk);
    msg_valid <= 1'b1;
    msg_dword5 <= {4'h0, BASE + r == 8'h00 ? 7'h01 : r, sb & al, 5'h00,
      l, tag_ff};
    tag_ff <= tag_ff + 8'h11;
    msg_segment <= SEG;
    {gateway_open, msg_notify, acknowledge_request} <= fl;
    do @(posedge pclk); while (msg_ready !== 1'b1);
    msg_valid <= 1'b0;
    msg_dword5 <= ~msg_dword5;
    msg_segment <= ~msg_segment;
  endtask
endmodule
`default_nettype wire

// >>> tb/forward_message_payload_decode_test.sv
`timescale 1ns/100ps
`default_nettype none
module forward_message_payload_decode_test;
  localparam logic [127:0] SEG = 128'h33333333_22222222_11111111_8C8C8C8C;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, errv;
  logic msg_valid, msg_ready, msg_notify, acknowledge_request, gateway_open;
  logic rf_wr_valid, notify_pulse, wb_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, wb_dword, rf_wr_byte_en, msg_dword5;
  logic [7:0] gateway_register_base, rf_wr_reg;
  logic [127:0] msg_segment;
  logic [255:0] rf_wr_data;
  int errors = 0;
  int total_checks = 0;
  fmpd_forward_decode uut (.*);
  fmpd_thread_model #(.SEG(SEG)) snd (.*);
  task chk(input logic [255:0] g, input logic [255:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {errv, rdv} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    #1;
  endtask
  task send(input logic [4:0] sb, input logic [2:0] l, input logic [2:0] fl);
    snd.send(7'h15, sb, l, fl);
    #1;
  endtask
  task stop_test;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #20000;
    errors++;
    stop_test;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rdv, 32'h1);
    apb(0, 12'h020, 0);
    chk({errv, rdv}, 33'h1_0000_0000);
    for (int l = 0; l < 8; l++)
    begin
      send(5'h10, l[2:0], 3'h5);
      chk({rf_wr_valid, wb_valid, wb_dword},
        {l < 5, 1'b1, l < 5 ? 32'h0 : 32'h6});
      if (l < 5)
      begin
        chk(rf_wr_reg, 8'h05);
        chk(rf_wr_byte_en, 32'(((64'h1 << (1 << l)) - 64'h1) << 16));
        chk(rf_wr_data, {SEG, 128'h0});
      end
    end
    send(5'h07, 3'h0, 3'h4);
    chk({rf_wr_valid, wb_valid, rf_wr_byte_en}, {2'b10, 32'h80});
    send(5'h1E, 3'h1, 3'h6);
    chk({notify_pulse, rf_wr_byte_en}, {1'b1, 32'hC0000000});
    send(5'h10, 3'h2, 3'h3);
    chk({rf_wr_valid, notify_pulse, wb_valid, wb_dword}, {3'b001, 32'h2});
    apb(0, 12'h004, 0);
    chk({irq, rdv}, 33'h7);
    apb(1, 12'h008, 32'h1);
    chk(irq, 1'b1);
    apb(0, 12'h008, 0);
    chk(rdv, 32'h1);
    apb(1, 12'h004, 32'h7);
    chk(irq, 1'b0);
    apb(0, 12'h004, 0);
    chk(rdv, 32'h0);
    apb(0, 12'h00C, 0);
    chk(rdv, 32'h7);
    apb(1, 12'h000, 32'h30);
    chk(msg_ready, 1'b0);
    apb(1, 12'h000, 32'h31);
    send(5'h10, 3'h4, 3'h5);
    chk(wb_dword, 32'h30000);
    apb(0, 12'h010, 0);
    chk(rdv, 32'h00010560);
    stop_test;
  end
endmodule
`default_nettype wire
